// ---- rtl/ufp_top.sv ----
`timescale 1ns/100ps
module ufp_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ufp_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [ufp_pkg::DATA_W-1:0] wb_dat_i,
    input wire logic wb_sel_i,
    output logic [ufp_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic bus_reset_seen,
    input wire logic bus_suspend_seen,
    input wire logic bus_resume_seen,
    input wire logic sof_seen,
    input wire logic [ufp_pkg::FRAME_W-1:0] sof_frame,
    input wire logic [ufp_pkg::NUM_IN_EP-1:0] in_ep_event,
    input wire logic iso_in_token,
    input wire logic iso_in_packet_armed,
    input wire logic cpu_ext_irq_enable,
    output logic usb_irq,
    output logic drive_resume,
    output logic osc_wake,
    output logic traffic_enable,
    output logic ep_flush,
    output logic iso_send_packet,
    output logic iso_send_zero_len,
    output logic [6:0] function_address
);
    import ufp_pkg::*;

    logic soft_rst_n;
    logic soft_rst_req_reg;
    logic rst_n_all;
    ufp_pwr_e pwr_state_reg;
    logic suspend_detect_enable_reg, resume_reg, inhibit_reg, iso_update_enable_reg;
    logic [6:0] function_address_reg_reg;
    logic [7:0] index_reg;
    logic [NUM_IN_EP-1:0] in_flags_reg, in_ie_reg;
    logic [3:0] cm_flags_reg, cm_ie_reg;
    logic [FRAME_W-1:0] frame_reg;
    logic iso_wait_reg;
    logic armed_prev_reg, armed_rise;
    logic acc, wr, rd;
    logic rd_in, rd_cm, wr_power;
    logic bus_rst, susp_ev, rsu_ev, wake_end_ev;
    logic [3:0] cm_set;
    logic [7:0] power_rd;

    // Software reset pulses one cycle, combined with power-on reset
    assign soft_rst_n = ~soft_rst_req_reg;
    assign rst_n_all = rst_n & soft_rst_n;

    assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = acc & wb_we_i & wb_sel_i;
    assign rd = acc & ~wb_we_i;
    assign rd_in = rd && wb_adr_i == OFS_IN_FLAGS;
    assign rd_cm = rd && wb_adr_i == OFS_CM_FLAGS;
    assign wr_power = wr && wb_adr_i == OFS_POWER;

    // Bus events are ignored while inhibited
    assign bus_rst = bus_reset_seen & ~inhibit_reg;
    assign susp_ev = bus_suspend_seen & suspend_detect_enable_reg & ~inhibit_reg
        & pwr_state_reg == UFP_ACTIVE;
    assign rsu_ev = bus_resume_seen & ~inhibit_reg & pwr_state_reg == UFP_SUSPENDED;
    assign wake_end_ev = wr_power & ~wb_dat_i[PWR_RESUME] & pwr_state_reg == UFP_WAKING;

    assign cm_set[CM_SUS] = susp_ev;
    assign cm_set[CM_RSU] = rsu_ev | wake_end_ev;
    assign cm_set[CM_RST] = bus_rst;
    assign cm_set[CM_SOF] = sof_seen & ~inhibit_reg;

    // Only a newly armed packet waits for the next frame
    assign armed_rise = iso_in_packet_armed & ~armed_prev_reg;

    function automatic logic [7:0] pad4(input logic [3:0] v);
        return {4'h0, v};
    endfunction

    always_comb begin
        power_rd = 8'h00;
        power_rd[PWR_ISO_UPDATE_ENABLE] = iso_update_enable_reg;
        power_rd[PWR_INHIBIT] = inhibit_reg;
        power_rd[PWR_BUSRST] = bus_reset_seen;
        power_rd[PWR_RESUME] = resume_reg;
        power_rd[PWR_SUSPEND_MODE_FLAG] = pwr_state_reg != UFP_ACTIVE;
        power_rd[PWR_SUSPEND_DETECT_ENABLE] = suspend_detect_enable_reg;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_rst_req_reg <= 1'b0;
        end else begin
            soft_rst_req_reg <= wr_power & wb_dat_i[PWR_BUSRST];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= UNMAPPED_READ;
        end else begin
            wb_ack_o <= acc;
            if (rd) begin
                unique case (wb_adr_i)
                    OFS_FUNCTION_ADDRESS_REG: wb_dat_o <= {1'b0, function_address_reg_reg};
                    OFS_POWER: wb_dat_o <= power_rd;
                    OFS_IN_FLAGS: wb_dat_o <= pad4(in_flags_reg);
                    OFS_CM_FLAGS: wb_dat_o <= pad4(cm_flags_reg);
                    OFS_IN_IE: wb_dat_o <= pad4(in_ie_reg);
                    OFS_CM_IE: wb_dat_o <= pad4(cm_ie_reg);
                    OFS_FRAME_LOW: wb_dat_o <= frame_reg[FRAME_LOW_W-1:0];
                    OFS_FRAME_HIGH: wb_dat_o <= {5'h00, frame_reg[FRAME_W-1:FRAME_LOW_W]};
                    OFS_INDEX: wb_dat_o <= index_reg;
                    default: wb_dat_o <= UNMAPPED_READ;
                endcase
            end
        end
    end

    // Power control bits
    always_ff @(posedge ref_clk or negedge rst_n_all) begin
        if (!rst_n_all) begin
            suspend_detect_enable_reg <= 1'b0;
            resume_reg <= 1'b0;
            iso_update_enable_reg <= 1'b0;
            inhibit_reg <= 1'b1;
        end else if (wr_power) begin
            suspend_detect_enable_reg <= wb_dat_i[PWR_SUSPEND_DETECT_ENABLE];
            resume_reg <= wb_dat_i[PWR_RESUME] & pwr_state_reg != UFP_ACTIVE;
            iso_update_enable_reg <= wb_dat_i[PWR_ISO_UPDATE_ENABLE];
            inhibit_reg <= inhibit_reg & wb_dat_i[PWR_INHIBIT];
        end
    end

    // Suspend state
    always_ff @(posedge ref_clk or negedge rst_n_all) begin
        if (!rst_n_all) begin
            pwr_state_reg <= UFP_ACTIVE;
        end else if (bus_rst) begin
            pwr_state_reg <= UFP_ACTIVE;
        end else begin
            unique case (pwr_state_reg)
                UFP_ACTIVE: if (susp_ev) pwr_state_reg <= UFP_SUSPENDED;
                UFP_SUSPENDED: begin
                    if (rsu_ev) begin
                        pwr_state_reg <= UFP_HOST_RESUMED;
                    end else if (wr_power && wb_dat_i[PWR_RESUME]) begin
                        pwr_state_reg <= UFP_WAKING;
                    end
                end
                UFP_WAKING: if (wake_end_ev) pwr_state_reg <= UFP_ACTIVE;
                UFP_HOST_RESUMED: if (rd_cm) pwr_state_reg <= UFP_ACTIVE;
            endcase
        end
    end

    // Function address, index and enables
    always_ff @(posedge ref_clk or negedge rst_n_all) begin
        if (!rst_n_all) begin
            function_address_reg_reg <= 7'h00;
            index_reg <= 8'h00;
            in_ie_reg <= IN_IE_RESET;
            cm_ie_reg <= CM_IE_RESET;
        end else if (bus_rst) begin
            function_address_reg_reg <= 7'h00;
            index_reg <= 8'h00;
            in_ie_reg <= IN_IE_ON_BUSRST;
            cm_ie_reg <= CM_IE_ON_BUSRST;
        end else if (wr) begin
            if (wb_adr_i == OFS_FUNCTION_ADDRESS_REG) function_address_reg_reg <= wb_dat_i[6:0];
            if (wb_adr_i == OFS_INDEX) index_reg <= wb_dat_i;
            if (wb_adr_i == OFS_IN_IE) in_ie_reg <= wb_dat_i[NUM_IN_EP-1:0];
            if (wb_adr_i == OFS_CM_IE) cm_ie_reg <= wb_dat_i[3:0];
        end
    end

    // Flags: clear on read, set wins
    always_ff @(posedge ref_clk or negedge rst_n_all) begin
        if (!rst_n_all) begin
            in_flags_reg <= '0;
            cm_flags_reg <= '0;
        end else if (bus_rst) begin
            in_flags_reg <= '0;
            cm_flags_reg <= CM_IE_ON_BUSRST[CM_RST] ? 4'h4 : 4'h0;
        end else begin
            in_flags_reg <= (rd_in ? '0 : in_flags_reg)
                | (in_ep_event & {NUM_IN_EP{~inhibit_reg}});
            cm_flags_reg <= (rd_cm ? 4'h0 : cm_flags_reg) | cm_set;
        end
    end

    // Frame number and iso gating
    always_ff @(posedge ref_clk or negedge rst_n_all) begin
        if (!rst_n_all) begin
            frame_reg <= '0;
            iso_wait_reg <= 1'b0;
            armed_prev_reg <= 1'b0;
        end else begin
            armed_prev_reg <= iso_in_packet_armed;
            if (sof_seen && !inhibit_reg) frame_reg <= sof_frame;
            if (sof_seen) begin
                iso_wait_reg <= 1'b0;
            end else if (armed_rise && iso_update_enable_reg) begin
                iso_wait_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_all) begin
        if (!rst_n_all) begin
            usb_irq <= 1'b0;
            drive_resume <= 1'b0;
            osc_wake <= 1'b0;
            traffic_enable <= 1'b0;
            ep_flush <= 1'b0;
            iso_send_packet <= 1'b0;
            iso_send_zero_len <= 1'b0;
            function_address <= 7'h00;
        end else begin
            // Suspend flag only reaches the request when enabled
            usb_irq <= cpu_ext_irq_enable & (|(in_flags_reg & in_ie_reg)
                | |(cm_flags_reg & cm_ie_reg));
            drive_resume <= pwr_state_reg == UFP_WAKING & resume_reg;
            osc_wake <= pwr_state_reg != UFP_ACTIVE & (rsu_ev | bus_rst
                | (wr_power & wb_dat_i[PWR_RESUME]));
            traffic_enable <= ~inhibit_reg;
            ep_flush <= bus_rst;
            iso_send_packet <= iso_in_token & ~inhibit_reg & iso_in_packet_armed
                & ~(iso_update_enable_reg & (iso_wait_reg | armed_rise & ~sof_seen));
            iso_send_zero_len <= iso_in_token & ~inhibit_reg & iso_update_enable_reg
                & (iso_wait_reg | armed_rise & ~sof_seen);
            function_address <= function_address_reg_reg;
        end
    end

    property p_inhibit_sticky;
        @(posedge ref_clk) disable iff (!rst_n_all)
        !inhibit_reg |=> !inhibit_reg;
    endproperty
    chk_inhibit_no_set: assert property (p_inhibit_sticky)
        else $error("inhibit set by software");

    chk_flag_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        cm_set[CM_SUS] && !bus_rst |=> cm_flags_reg[CM_SUS])
        else $error("suspend flag lost");

    chk_read_clears: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        rd_in && !bus_rst && in_ep_event == '0 |=> in_flags_reg == '0)
        else $error("in flags not cleared by read");

    chk_busrst_addr: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        bus_rst |=> function_address_reg_reg == 7'h00 && cm_ie_reg == CM_IE_ON_BUSRST)
        else $error("bus reset side effects missing");

    chk_susp_enter: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        susp_ev && !bus_rst |=> pwr_state_reg == UFP_SUSPENDED)
        else $error("suspend not entered");

    chk_no_susp_dis: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        pwr_state_reg == UFP_ACTIVE && !suspend_detect_enable_reg |=> pwr_state_reg == UFP_ACTIVE)
        else $error("suspend entered while detection off");

    sequence s_wake_end;
        pwr_state_reg == UFP_WAKING && wake_end_ev && !bus_rst;
    endsequence
    chk_wake_end: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        s_wake_end |=> pwr_state_reg == UFP_ACTIVE && cm_flags_reg[CM_RSU]
        ##1 !drive_resume)
        else $error("remote wakeup did not end");

    chk_host_resume: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        rsu_ev && !bus_rst |=> pwr_state_reg == UFP_HOST_RESUMED && cm_flags_reg[CM_RSU])
        else $error("host resume not handled");

    chk_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        !cpu_ext_irq_enable |=> !usb_irq)
        else $error("irq without processor enable");

    chk_iso_zero: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        iso_in_token && !inhibit_reg && iso_update_enable_reg && iso_wait_reg |=> iso_send_zero_len
        && !iso_send_packet)
        else $error("iso zero length packet missing");

    chk_inhibit_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        inhibit_reg |=> !iso_send_packet && !ep_flush)
        else $error("traffic while inhibited");

    chk_flush_on_reset: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        bus_rst |=> ep_flush && index_reg == 8'h00)
        else $error("bus reset did not flush");

    chk_reset_flag: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        bus_rst |=> cm_flags_reg[CM_RST] && !cm_flags_reg[CM_SUS])
        else $error("reset flag wrong after bus reset");

    chk_reset_status: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        bus_reset_seen |-> power_rd[PWR_BUSRST])
        else $error("bus reset status not shown");

    chk_soft_defaults: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_power && wb_dat_i[PWR_BUSRST] |=> inhibit_reg && !suspend_detect_enable_reg && !iso_update_enable_reg
        && !resume_reg && pwr_state_reg == UFP_ACTIVE)
        else $error("soft reset left state behind");

    sequence s_susp_seen;
        susp_ev && !bus_rst && cm_ie_reg[CM_SUS];
    endsequence
    chk_susp_irq: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        s_susp_seen ##1 cpu_ext_irq_enable |=> usb_irq)
        else $error("suspend interrupt missing");

    chk_irq_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        in_flags_reg == '0 && (cm_flags_reg & cm_ie_reg) == 4'h0 |=> !usb_irq)
        else $error("interrupt without enabled flag");

    chk_osc_wake: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        pwr_state_reg != UFP_ACTIVE && (rsu_ev || bus_rst) |=> osc_wake)
        else $error("oscillator not woken");

    chk_busrst_exit: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        bus_rst |=> pwr_state_reg == UFP_ACTIVE)
        else $error("bus reset did not leave suspend");

    sequence s_wake_start;
        pwr_state_reg == UFP_SUSPENDED && !rsu_ev && !bus_rst
        && wr_power && wb_dat_i[PWR_RESUME];
    endsequence
    chk_remote_wake: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        s_wake_start |=> ##1 drive_resume)
        else $error("remote wakeup not driven");

    chk_frame_capture: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        sof_seen && !inhibit_reg |=> frame_reg == $past(sof_frame))
        else $error("frame number not captured");

    chk_iso_hold: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        armed_rise && iso_update_enable_reg && !sof_seen |=> iso_wait_reg)
        else $error("iso packet not held");

    chk_iso_release: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        sof_seen |=> !iso_wait_reg)
        else $error("iso packet not released on frame");

    chk_resume_read: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        pwr_state_reg == UFP_HOST_RESUMED && rd_cm && !bus_rst
        |=> pwr_state_reg == UFP_ACTIVE)
        else $error("suspend mode kept after flag read");

    chk_in_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n_all)
        in_ep_event != '0 && !inhibit_reg && !bus_rst
        |=> (in_flags_reg & $past(in_ep_event)) == $past(in_ep_event))
        else $error("endpoint flag lost");
endmodule // ufp_top

// ---- rtl/ufp_pkg.sv ----
package ufp_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets (index == byte address, all stand at printed offsets)
    localparam logic [7:0] OFS_FUNCTION_ADDRESS_REG = 8'h00;
    localparam logic [7:0] OFS_POWER = 8'h01;
    localparam logic [7:0] OFS_IN_FLAGS = 8'h02;
    localparam logic [7:0] OFS_CM_FLAGS = 8'h06;
    localparam logic [7:0] OFS_IN_IE = 8'h07;
    localparam logic [7:0] OFS_CM_IE = 8'h0B;
    localparam logic [7:0] OFS_FRAME_LOW = 8'h0C;
    localparam logic [7:0] OFS_FRAME_HIGH = 8'h0D;
    localparam logic [7:0] OFS_INDEX = 8'h0E;
    localparam logic [7:0] OFS_ISO_CTRL = 8'h10;

    // Power register bit positions
    localparam int PWR_SUSPEND_DETECT_ENABLE = 0;
    localparam int PWR_SUSPEND_MODE_FLAG = 1;
    localparam int PWR_RESUME = 2;
    localparam int PWR_BUSRST = 3;
    localparam int PWR_INHIBIT = 4;
    localparam int PWR_ISO_UPDATE_ENABLE = 7;

    // Common flag bit positions
    localparam int CM_SUS = 0;
    localparam int CM_RSU = 1;
    localparam int CM_RST = 2;
    localparam int CM_SOF = 3;

    localparam logic [7:0] POWER_RESET = 8'h10;
    localparam logic [3:0] IN_IE_RESET = 4'hF;
    localparam logic [3:0] CM_IE_RESET = 4'h6;
    localparam logic [3:0] CM_IE_ON_BUSRST = 4'hE;
    localparam logic [3:0] IN_IE_ON_BUSRST = 4'hF;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    localparam int NUM_IN_EP = 4;
    localparam int FRAME_W = 11;
    localparam int FRAME_LOW_W = 8;
    localparam int FRAME_HIGH_W = 3;

    typedef enum logic [1:0] {
        UFP_ACTIVE = 2'b00,
        UFP_SUSPENDED = 2'b01,
        UFP_WAKING = 2'b11,
        UFP_HOST_RESUMED = 2'b10
    } ufp_pwr_e;
endpackage

// ---- testbench/ufp_host_model.sv ----
`timescale 1ns/100ps
module ufp_host_model (
    input wire logic ref_clk,
    output logic bus_reset_seen,
    output logic bus_suspend_seen,
    output logic bus_resume_seen,
    output logic sof_seen,
    output logic [ufp_pkg::FRAME_W-1:0] sof_frame,
    output logic [ufp_pkg::NUM_IN_EP-1:0] in_ep_event,
    output logic iso_in_token
);
    import ufp_pkg::*;
    initial begin
        bus_reset_seen = 1'b0;
        bus_suspend_seen = 1'b0;
        bus_resume_seen = 1'b0;
        sof_seen = 1'b0;
        sof_frame = 11'h7FF;
        in_ep_event = 4'h0;
        iso_in_token = 1'b0;
    end
    // Bus event held for n cycles: 0 reset, 1 suspend, 2 resume, 3 sof, 4 ep, 5 token
    task automatic ev(input int code, input int n, input logic [10:0] val);
        @(posedge ref_clk);
        case (code)
            0: bus_reset_seen <= 1'b1;
            1: bus_suspend_seen <= 1'b1;
            2: bus_resume_seen <= 1'b1;
            3: begin
                sof_seen <= 1'b1;
                sof_frame <= val;
            end
            4: in_ep_event <= val[3:0];
            default: iso_in_token <= 1'b1;
        endcase
        repeat (n) @(posedge ref_clk);
        bus_reset_seen <= 1'b0;
        bus_suspend_seen <= 1'b0;
        bus_resume_seen <= 1'b0;
        sof_seen <= 1'b0;
        in_ep_event <= 4'h0;
        iso_in_token <= 1'b0;
        // Frame number is stale once the token is over
        sof_frame <= ~val;
    endtask
endmodule // ufp_host_model

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    import ufp_pkg::*;
    logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, usb_irq, drive_resume;
    logic [7:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
    logic bus_reset_seen, bus_suspend_seen, bus_resume_seen, sof_seen, iso_in_token;
    logic iso_in_packet_armed, cpu_ext_irq_enable, traffic_enable, ep_flush;
    logic iso_send_packet, iso_send_zero_len, flush_seen, pkt_seen, zl_seen;
    logic osc_wake, wake_seen;
    logic [10:0] sof_frame;
    logic [3:0] in_ep_event;
    logic [6:0] function_address;
    int n_mismatch = 0;
    int checks = 0;
    ufp_top u_ufp_top (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(1'b1), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .bus_reset_seen(bus_reset_seen), .bus_suspend_seen(bus_suspend_seen),
        .bus_resume_seen(bus_resume_seen), .sof_seen(sof_seen), .sof_frame(sof_frame),
        .in_ep_event(in_ep_event), .iso_in_token(iso_in_token),
        .iso_in_packet_armed(iso_in_packet_armed), .cpu_ext_irq_enable(cpu_ext_irq_enable),
        .usb_irq(usb_irq), .drive_resume(drive_resume), .osc_wake(osc_wake),
        .traffic_enable(traffic_enable), .ep_flush(ep_flush),
        .iso_send_packet(iso_send_packet), .iso_send_zero_len(iso_send_zero_len),
        .function_address(function_address));
    ufp_host_model u_ufp_host_model (.ref_clk(ref_clk), .bus_reset_seen(bus_reset_seen),
        .bus_suspend_seen(bus_suspend_seen), .bus_resume_seen(bus_resume_seen),
        .sof_seen(sof_seen), .sof_frame(sof_frame), .in_ep_event(in_ep_event),
        .iso_in_token(iso_in_token));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Sticky catchers for pulses that are over before they are checked
    always @(posedge ref_clk) begin
        if (ep_flush === 1'b1) flush_seen <= 1'b1;
        if (osc_wake === 1'b1) wake_seen <= 1'b1;
        if (iso_send_packet === 1'b1) pkt_seen <= 1'b1;
        if (iso_send_zero_len === 1'b1) zl_seen <= 1'b1;
    end
    task automatic conclude();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk1(input string nm, input logic exp, input logic got);
        chk(nm, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] adr, input logic [7:0] exp);
        wb(1'b0, adr, 8'h00);
        chk(nm, exp, rd);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic iso_try(input logic exp_pkt, input logic exp_zl);
        pkt_seen = 1'b0;
        zl_seen = 1'b0;
        u_ufp_host_model.ev(5, 1, 11'h000);
        wait_n(3);
        chk1("iso_send_packet", exp_pkt, pkt_seen);
        chk1("iso_send_zero_len", exp_zl, zl_seen);
    endtask
    task automatic s_defaults();
        rchk("power", OFS_POWER, POWER_RESET);
        rchk("unmapped", 8'h3F, UNMAPPED_READ);
        u_ufp_host_model.ev(4, 1, 11'h00F);
        wait_n(3);
        rchk("in_flags", OFS_IN_FLAGS, 8'h00);
        chk1("traffic_enable", 1'b0, traffic_enable);
    endtask
    task automatic s_config();
        wb(1'b1, OFS_POWER, 8'h08);
        wait_n(2);
        wb(1'b1, OFS_CM_IE, 8'h07);
        wb(1'b1, OFS_POWER, 8'h61);
        rchk("power", OFS_POWER, 8'h01);
        wb(1'b1, OFS_POWER, 8'h11);
        rchk("power", OFS_POWER, 8'h01);
        chk1("traffic_enable", 1'b1, traffic_enable);
    endtask
    task automatic s_flags();
        u_ufp_host_model.ev(4, 1, 11'h00A);
        wait_n(3);
        chk1("usb_irq", 1'b0, usb_irq);
        cpu_ext_irq_enable <= 1'b1;
        wait_n(2);
        chk1("usb_irq", 1'b1, usb_irq);
        rchk("in_flags", OFS_IN_FLAGS, 8'h0A);
        rchk("in_flags", OFS_IN_FLAGS, 8'h00);
        wait_n(2);
        chk1("usb_irq", 1'b0, usb_irq);
        u_ufp_host_model.ev(3, 1, 11'h5A3);
        rchk("frame_low", OFS_FRAME_LOW, 8'hA3);
        rchk("frame_high", OFS_FRAME_HIGH, 8'h05);
        rchk("cm_flags", OFS_CM_FLAGS, 8'h08);
    endtask
    task automatic s_suspend();
        u_ufp_host_model.ev(1, 2, 11'h000);
        wait_n(3);
        chk1("usb_irq", 1'b1, usb_irq);
        rchk("power", OFS_POWER, 8'h03);
        rchk("cm_flags", OFS_CM_FLAGS, 8'h01);
        u_ufp_host_model.ev(2, 2, 11'h000);
        wait_n(2);
        rchk("cm_flags", OFS_CM_FLAGS, 8'h02);
        rchk("power", OFS_POWER, 8'h01);
        wb(1'b1, OFS_POWER, 8'h00);
        u_ufp_host_model.ev(1, 2, 11'h000);
        wait_n(3);
        rchk("power", OFS_POWER, 8'h00);
        rchk("cm_flags", OFS_CM_FLAGS, 8'h00);
    endtask
    task automatic s_wakeup();
        wb(1'b1, OFS_POWER, 8'h01);
        u_ufp_host_model.ev(1, 2, 11'h000);
        wait_n(3);
        rchk("cm_flags", OFS_CM_FLAGS, 8'h01);
        wb(1'b1, OFS_POWER, 8'h05);
        wait_n(2);
        chk1("drive_resume", 1'b1, drive_resume);
        // Wakeup length shortened from the software guideline
        wait_n(20);
        wb(1'b1, OFS_POWER, 8'h01);
        wait_n(2);
        chk1("drive_resume", 1'b0, drive_resume);
        rchk("power", OFS_POWER, 8'h01);
        rchk("cm_flags", OFS_CM_FLAGS, 8'h02);
    endtask
    task automatic s_iso();
        wb(1'b1, OFS_POWER, 8'h81);
        iso_in_packet_armed <= 1'b1;
        iso_try(1'b0, 1'b1);
        u_ufp_host_model.ev(3, 1, 11'h001);
        iso_try(1'b1, 1'b0);
        iso_in_packet_armed <= 1'b0;
        wb(1'b1, OFS_POWER, 8'h01);
        iso_in_packet_armed <= 1'b1;
        iso_try(1'b1, 1'b0);
        iso_in_packet_armed <= 1'b0;
        rchk("cm_flags", OFS_CM_FLAGS, 8'h08);
    endtask
    task automatic s_bus_reset();
        wb(1'b1, OFS_FUNCTION_ADDRESS_REG, 8'h2A);
        wait_n(1);
        chk("function_address", 8'h2A, {1'b0, function_address});
        u_ufp_host_model.ev(1, 2, 11'h000);
        flush_seen = 1'b0;
        wake_seen = 1'b0;
        fork
            u_ufp_host_model.ev(0, 10, 11'h000);
            begin
                wait_n(4);
                rchk("power", OFS_POWER, 8'h09);
            end
        join
        wait_n(2);
        chk1("ep_flush", 1'b1, flush_seen);
        chk1("osc_wake", 1'b1, wake_seen);
        chk("function_address", 8'h00, {1'b0, function_address});
        rchk("power", OFS_POWER, 8'h01);
        rchk("cm_flags", OFS_CM_FLAGS, 8'h04);
        rchk("cm_ie", OFS_CM_IE, {4'h0, CM_IE_ON_BUSRST});
        rchk("in_ie", OFS_IN_IE, {4'h0, IN_IE_ON_BUSRST});
    endtask
    task automatic s_soft_reset();
        wb(1'b1, OFS_POWER, 8'h89);
        wait_n(2);
        rchk("power", OFS_POWER, POWER_RESET);
        rchk("cm_ie", OFS_CM_IE, {4'h0, CM_IE_RESET});
        chk1("traffic_enable", 1'b0, traffic_enable);
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        conclude();
    end
    initial begin
        {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, iso_in_packet_armed, cpu_ext_irq_enable} = 6'h00;
        {wb_adr_i, wb_dat_i} = 16'h0000;
        {flush_seen, pkt_seen, zl_seen, wake_seen} = 4'h0;
        wait_n(8);
        rst_n <= 1'b1;
        s_defaults();
        s_config();
        s_flags();
        s_suspend();
        s_wakeup();
        s_iso();
        s_bus_reset();
        s_soft_reset();
        conclude();
    end
endmodule // testbench
